// File: design/fbp_pkg.sv
// package: constants, register map and carrier types for flash boot protection
package fbp_pkg;
	localparam logic [12:0] FBP_BOOT_START_128 = 13'h1f80;
	localparam logic [12:0] FBP_BOOT_START_256 = 13'h1f00;
	localparam logic [12:0] FBP_BOOT_START_512 = 13'h1e00;
	localparam logic [12:0] FBP_BOOT_START_1K = 13'h1c00;
	localparam logic [10:0] FBP_BOOT_SIZE_128 = 11'h080;
	localparam logic [10:0] FBP_BOOT_SIZE_256 = 11'h100;
	localparam logic [10:0] FBP_BOOT_SIZE_512 = 11'h200;
	localparam logic [10:0] FBP_BOOT_SIZE_1K = 11'h400;
	localparam logic [12:0] FBP_RWW_LAST = 13'h1bff;
	localparam logic [12:0] FBP_NO_READ_WHILE_WRITE_AREA_FIRST = 13'h1c00;
	localparam int FBP_PC_W = 13;
	localparam int FBP_PAGE_LSB = 6;
	localparam int FBP_Z_PAGE_LSB = 7;
	localparam int FBP_Z_PAGE_MSB = 13;
	localparam int FBP_Z_WORD_LSB = 1;
	localparam int FBP_Z_WORD_MSB = 6;
	localparam int FBP_LK_BOOT_HI = 5;
	localparam int FBP_LK_BOOT_LO = 4;
	localparam int FBP_LK_APP_HI = 3;
	localparam int FBP_LK_APP_LO = 2;
	localparam int FBP_LK_MEM_HI = 1;
	localparam int FBP_LK_MEM_LO = 0;
	localparam logic [7:0] FBP_LOCK_RESET = 8'hff;
	localparam logic [7:0] FBP_LOCK_UNUSED = 8'hc0;
	// apb byte addresses
	localparam logic [7:0] FBP_A_LOCK = 8'h00;
	localparam logic [7:0] FBP_A_CTRL = 8'h04;
	localparam logic [7:0] FBP_A_STATUS = 8'h08;
	localparam logic [7:0] FBP_A_ZPTR = 8'h0c;
	localparam logic [7:0] FBP_A_DATA = 8'h10;
	localparam logic [7:0] FBP_A_CHECK = 8'h14;
	// control register bits
	localparam int FBP_C_SPM_EN = 0;
	localparam int FBP_C_PG_ERASE = 1;
	localparam int FBP_C_PG_WRITE = 2;
	localparam int FBP_C_LOCK_SET = 3;
	localparam int FBP_C_RWW_REEN = 4;
	localparam int FBP_C_CHIP_ERASE = 7;
	localparam int FBP_C_IVSEL = 8;
	localparam int FBP_C_EXEC_BOOT = 9;
	localparam int FBP_C_PARALLEL = 10;
	localparam int FBP_C_SERIAL = 11;
	localparam logic [7:0] FBP_OP_CYCLES = 8'h20;
	typedef enum logic [1:0] {FBP_ACC_FILL, FBP_ACC_ERASE, FBP_ACC_WRITE, FBP_ACC_READ} fbp_acc_t;
	typedef struct packed {
		logic [6:0] page;
		logic [5:0] word;
		logic byte_sel;
	} fbp_addr_t;
	typedef struct packed {
		logic boot_start_ok;
		logic [12:0] boot_start;
		logic [10:0] boot_size;
	} fbp_part_t;
endpackage : fbp_pkg

// File: design/fbp_page_buf.sv
// temporary page buffer, 64 words with registered read
`timescale 1ns/1ps
module fbp_page_buf import fbp_pkg::*; (
	input wire logic i_core_clk,
	input wire logic i_we,
	input wire logic [5:0] i_waddr,
	input wire logic [15:0] i_wdata,
	input wire logic [5:0] i_raddr,
	output logic [15:0] o_rdata
);
	logic [15:0] mem [0:63];
	always_ff @(posedge i_core_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end
endmodule : fbp_page_buf

// File: design/fbp_flash_protect.sv
// flash boot section partitioning and lock-bit protection, apb slave
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module fbp_flash_protect import fbp_pkg::*; (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_boot_size_select_hi,
	input wire logic i_boot_size_select_lo,
	input wire logic i_eeprom_write_strobe,
	output logic o_rww_busy_flag,
	output logic o_irq_allow,
	output logic o_ext_prog_block,
	output logic o_ext_verify_block,
	output logic o_fuse_lock,
	output logic o_boot_lock_locked
);
	logic [1:0] bsz_s1_reg;
	logic [1:0] bsz_reg;
	logic ee_s1_reg;
	logic ee_reg;
	logic [5:0] lock_reg;
	logic [11:0] ctrl_reg;
	logic [15:0] zptr_reg;
	logic [15:0] data_reg;
	logic [7:0] op_cnt_reg;
	fbp_acc_t op_kind_reg;
	logic spm_busy_reg;
	logic rww_busy_reg;
	logic rej_reg;
	logic [15:0] rd_reg;
	logic [15:0] buf_rdata;
	logic [12:0] check_reg;
	fbp_part_t part;
	fbp_addr_t za;
	logic [12:0] zword;
	logic ap_wr, ap_go;
	logic app_wr_lock, app_rd_lock, boot_wr_lock, boot_rd_lock;
	logic exec_boot, ivsel;
	logic cmd_go;
	logic [11:0] cmd;
	logic tgt_boot, store_ok, load_ok, buf_we;
	function automatic fbp_part_t fbp_decode(input logic [1:0] sz);
		fbp_part_t p;
		p.boot_start_ok = 1'b1;
		case (sz)
			2'b11: begin p.boot_start = FBP_BOOT_START_128; p.boot_size = FBP_BOOT_SIZE_128; end
			2'b10: begin p.boot_start = FBP_BOOT_START_256; p.boot_size = FBP_BOOT_SIZE_256; end
			2'b01: begin p.boot_start = FBP_BOOT_START_512; p.boot_size = FBP_BOOT_SIZE_512; end
			default: begin p.boot_start = FBP_BOOT_START_1K; p.boot_size = FBP_BOOT_SIZE_1K; end
		endcase
		return p;
	endfunction : fbp_decode
	function automatic logic fbp_in_boot(input logic [12:0] a, input logic [12:0] start);
		return a >= start;
	endfunction : fbp_in_boot
	function automatic logic fbp_in_rww(input logic [12:0] a);
		return a <= FBP_RWW_LAST;
	endfunction : fbp_in_rww
	// pin synchronisers
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bsz_s1_reg <= 2'h3;
			bsz_reg <= 2'h3;
			ee_s1_reg <= 1'b0;
			ee_reg <= 1'b0;
		end else begin
			bsz_s1_reg <= {i_boot_size_select_hi, i_boot_size_select_lo};
			bsz_reg <= bsz_s1_reg;
			ee_s1_reg <= i_eeprom_write_strobe;
			ee_reg <= ee_s1_reg;
		end
	end
	assign part = fbp_decode(bsz_reg);
	// pointer mapping, top two bits dropped
	assign za = {zptr_reg[FBP_Z_PAGE_MSB:FBP_Z_PAGE_LSB],
		zptr_reg[FBP_Z_WORD_MSB:FBP_Z_WORD_LSB],
		zptr_reg[0]};
	assign zword = {za.page, za.word};
	assign exec_boot = ctrl_reg[FBP_C_EXEC_BOOT];
	assign ivsel = ctrl_reg[FBP_C_IVSEL];
	assign app_wr_lock = !lock_reg[FBP_LK_APP_LO];
	assign app_rd_lock = !lock_reg[FBP_LK_APP_HI];
	assign boot_wr_lock = !lock_reg[FBP_LK_BOOT_LO];
	assign boot_rd_lock = !lock_reg[FBP_LK_BOOT_HI];
	// apb decode
	assign ap_go = i_psel & i_penable & o_pready;
	assign ap_wr = ap_go & i_pwrite;
	assign cmd = i_pwdata[11:0];
	assign cmd_go = ap_wr && (i_paddr == FBP_A_CTRL) && cmd[FBP_C_SPM_EN] && !spm_busy_reg
		&& !ee_reg;
	assign tgt_boot = fbp_in_boot(zword, part.boot_start);
	always_comb begin
		store_ok = 1'b1;
		if (tgt_boot && boot_wr_lock) begin
			store_ok = 1'b0;
		end else if (!tgt_boot && app_wr_lock) begin
			store_ok = 1'b0;
		end
	end
	always_comb begin
		load_ok = 1'b1;
		if (exec_boot && !tgt_boot && app_rd_lock) begin
			load_ok = 1'b0;
		end else if (!exec_boot && tgt_boot && boot_rd_lock) begin
			load_ok = 1'b0;
		end else if (fbp_in_rww(zword) && rww_busy_reg) begin
			load_ok = 1'b0;
		end
	end
	assign buf_we = cmd_go && (cmd[4:1] == 4'h0) && store_ok;
	fbp_page_buf u_buf (
		.i_core_clk(i_core_clk),
		.i_we(buf_we),
		.i_waddr(za.word),
		.i_wdata(data_reg),
		.i_raddr(za.word),
		.o_rdata(buf_rdata)
	);
	// software registers
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_reg <= 12'h000;
			zptr_reg <= 16'h0000;
			data_reg <= 16'h0000;
		end else if (ap_wr) begin
			if (i_paddr == FBP_A_CTRL) begin
				ctrl_reg <= {cmd[11:8], ctrl_reg[7:1], cmd_go};
			end else if (i_paddr == FBP_A_ZPTR) begin
				zptr_reg <= i_pwdata[15:0];
			end else if (i_paddr == FBP_A_DATA) begin
				data_reg <= i_pwdata[15:0];
			end
		end else if (!spm_busy_reg) begin
			ctrl_reg[FBP_C_SPM_EN] <= 1'b0;
		end
	end
	// lock bits: program to zero only, chip erase restores
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			lock_reg <= FBP_LOCK_RESET[5:0];
		end else if (ap_wr && i_paddr == FBP_A_CTRL && cmd[FBP_C_CHIP_ERASE]) begin
			lock_reg <= FBP_LOCK_RESET[5:0];
		end else if (cmd_go && cmd[FBP_C_LOCK_SET]) begin
			lock_reg <= lock_reg & data_reg[5:0];
		end
	end
	// self-programming operation timer
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			spm_busy_reg <= 1'b0;
			op_cnt_reg <= 8'h00;
			op_kind_reg <= FBP_ACC_FILL;
			rej_reg <= 1'b0;
		end else if (cmd_go) begin
			spm_busy_reg <= 1'b1;
			op_cnt_reg <= FBP_OP_CYCLES;
			rej_reg <= (cmd[FBP_C_PG_ERASE] | cmd[FBP_C_PG_WRITE]) & !store_ok;
			if (cmd[FBP_C_PG_ERASE]) begin
				op_kind_reg <= FBP_ACC_ERASE;
			end else if (cmd[FBP_C_PG_WRITE]) begin
				op_kind_reg <= FBP_ACC_WRITE;
			end else begin
				op_kind_reg <= FBP_ACC_FILL;
			end
		end else if (op_cnt_reg != 8'h00) begin
			op_cnt_reg <= op_cnt_reg - 8'h01;
		end else begin
			spm_busy_reg <= 1'b0;
		end
	end
	// rww busy: set by erase or write in rww area, cleared by re-enable
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rww_busy_reg <= 1'b0;
		end else if (cmd_go && (cmd[FBP_C_PG_ERASE] | cmd[FBP_C_PG_WRITE]) && store_ok
			&& fbp_in_rww(zword)) begin
			rww_busy_reg <= 1'b1;
		end else if (cmd_go && cmd[FBP_C_RWW_REEN] && !spm_busy_reg) begin
			rww_busy_reg <= 1'b0;
		end
	end
	// program-load result: buffer byte or zero when refused
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rd_reg <= 16'h0000;
			check_reg <= 13'h0000;
		end else begin
			rd_reg <= load_ok ? {8'h00, za.byte_sel ? buf_rdata[15:8] : buf_rdata[7:0]} :
				16'h0000;
			check_reg <= {tgt_boot, !fbp_in_rww(zword), load_ok, store_ok, za.page, 2'h0};
		end
	end
	// apb slave: one wait state, unmapped gives pslverr
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h00000000;
			o_pslverr <= 1'b0;
		end else if (i_psel && i_penable && !o_pready) begin
			o_pready <= 1'b1;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h00000000;
			if (i_paddr == FBP_A_LOCK) begin
				o_prdata <= {24'h000000, FBP_LOCK_UNUSED | {2'h0, lock_reg}};
			end else if (i_paddr == FBP_A_CTRL) begin
				o_prdata <= {20'h00000, ctrl_reg};
			end else if (i_paddr == FBP_A_STATUS) begin
				o_prdata <= {8'h00, part.boot_start, part.boot_size[10:7], rej_reg, ee_reg,
					spm_busy_reg, rww_busy_reg, bsz_reg, 1'b0};
			end else if (i_paddr == FBP_A_ZPTR) begin
				o_prdata <= {16'h0000, zptr_reg};
			end else if (i_paddr == FBP_A_DATA) begin
				o_prdata <= {16'h0000, rd_reg};
			end else if (i_paddr == FBP_A_CHECK) begin
				o_prdata <= {19'h00000, check_reg};
			end else begin
				o_pslverr <= 1'b1;
			end
		end else begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end
	end
	// lock outputs and interrupt gate
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rww_busy_flag <= 1'b0;
			o_irq_allow <= 1'b1;
			o_ext_prog_block <= 1'b0;
			o_ext_verify_block <= 1'b0;
			o_fuse_lock <= 1'b0;
			o_boot_lock_locked <= 1'b0;
		end else begin
			o_rww_busy_flag <= rww_busy_reg;
			o_irq_allow <= !((ivsel && !exec_boot && app_rd_lock)
				|| (!ivsel && exec_boot && boot_rd_lock));
			o_ext_prog_block <= !lock_reg[FBP_LK_MEM_LO];
			o_fuse_lock <= !lock_reg[FBP_LK_MEM_LO];
			o_ext_verify_block <= !lock_reg[FBP_LK_MEM_LO] && !lock_reg[FBP_LK_MEM_HI];
			o_boot_lock_locked <= !lock_reg[FBP_LK_MEM_LO] && !lock_reg[FBP_LK_MEM_HI];
		end
	end
	// checks
	property p_spm_hold;
		@(posedge i_core_clk) disable iff (!i_resetn)
		cmd_go |=> spm_busy_reg [*8];
	endproperty
	a_spm_hold: assert property (p_spm_hold) else $error("enable dropped early");
	property p_rww_set;
		@(posedge i_core_clk) disable iff (!i_resetn)
		rww_busy_reg && !(cmd_go && cmd[FBP_C_RWW_REEN]) |=> rww_busy_reg;
	endproperty
	a_rww_set: assert property (p_rww_set) else $error("rww busy cleared wrongly");
	property p_lock_mono;
		@(posedge i_core_clk) disable iff (!i_resetn)
		!(ap_wr && cmd[FBP_C_CHIP_ERASE]) |=> (lock_reg & ~$past(lock_reg)) == 6'h00;
	endproperty
	a_lock_mono: assert property (p_lock_mono) else $error("lock bit rose");
	property p_boot_wr;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(tgt_boot && !lock_reg[FBP_LK_BOOT_LO]) |-> !store_ok;
	endproperty
	a_boot_wr: assert property (p_boot_wr) else $error("boot write allowed");
	property p_app_wr;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(!tgt_boot && !lock_reg[FBP_LK_APP_LO]) |-> !store_ok;
	endproperty
	a_app_wr: assert property (p_app_wr) else $error("app write allowed");
	property p_irq;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(ivsel && !exec_boot && !lock_reg[FBP_LK_APP_HI]) |=> !o_irq_allow;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not masked");
	property p_mem_free;
		@(posedge i_core_clk) disable iff (!i_resetn)
		lock_reg[1:0] == 2'h3 |=> !o_ext_prog_block && !o_fuse_lock;
	endproperty
	a_mem_free: assert property (p_mem_free) else $error("lock with pair 11");
	property p_mem_full;
		@(posedge i_core_clk) disable iff (!i_resetn)
		lock_reg[1:0] == 2'h0 |=> o_ext_verify_block && o_ext_prog_block;
	endproperty
	a_mem_full: assert property (p_mem_full) else $error("pair 00 not locked");
	property p_boot_start;
		@(posedge i_core_clk) disable iff (!i_resetn)
		bsz_reg == 2'h0 |-> part.boot_start == FBP_NO_READ_WHILE_WRITE_AREA_FIRST;
	endproperty
	a_boot_start: assert property (p_boot_start) else $error("boot start wrong");
	property p_app_rd;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(exec_boot && !tgt_boot && !lock_reg[FBP_LK_APP_HI]) |=> rd_reg == 16'h0000;
	endproperty
	a_app_rd: assert property (p_app_rd) else $error("app read allowed");
	property p_boot_rd;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(!exec_boot && tgt_boot && !lock_reg[FBP_LK_BOOT_HI]) |=> rd_reg == 16'h0000;
	endproperty
	a_boot_rd: assert property (p_boot_rd) else $error("boot read allowed");
	property p_irq_boot;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(!ivsel && exec_boot && !lock_reg[FBP_LK_BOOT_HI]) |=> !o_irq_allow;
	endproperty
	a_irq_boot: assert property (p_irq_boot) else $error("boot interrupt not masked");
	property p_mem_prog;
		@(posedge i_core_clk) disable iff (!i_resetn)
		!lock_reg[FBP_LK_MEM_LO] |=> o_ext_prog_block && o_fuse_lock;
	endproperty
	a_mem_prog: assert property (p_mem_prog) else $error("pair 10 not locked");
	property p_rej_kind;
		@(posedge i_core_clk) disable iff (!i_resetn)
		rej_reg |-> op_kind_reg != FBP_ACC_FILL;
	endproperty
	a_rej_kind: assert property (p_rej_kind) else $error("reject on fill");
	// store into rww area, then busy flag shown
	sequence s_rww_store;
		cmd_go && (cmd[FBP_C_PG_ERASE] | cmd[FBP_C_PG_WRITE]) && store_ok && fbp_in_rww(zword);
	endsequence
	sequence s_rww_shown;
		rww_busy_reg ##1 o_rww_busy_flag;
	endsequence
	property p_rww_busy;
		@(posedge i_core_clk) disable iff (!i_resetn)
		s_rww_store |=> s_rww_shown;
	endproperty
	a_rww_busy: assert property (p_rww_busy) else $error("rww busy not set");
endmodule : fbp_flash_protect

// File: verif/fbp_core_model.sv
// processor core model: apb master issuing self-programming commands
`timescale 1ns/1ps
module fbp_core_model import fbp_pkg::*; (
	input wire logic i_core_clk,
	input wire logic [31:0] i_prdata,
	input wire logic i_pready,
	input wire logic i_pslverr,
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [7:0] o_paddr,
	output logic [31:0] o_pwdata
);
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 8'h00;
		o_pwdata = 32'h0;
	end
	task automatic hang();
		tb.err_total++;
		tb.end_sim();
	endtask : hang
	// one apb transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge i_core_clk);
		o_psel <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_core_clk);
		o_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (i_pready !== 1'b1 && n < 64);
		if (n >= 64) begin
			hang();
		end
		r = i_prdata;
		e = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		o_paddr <= ~a;
		o_pwdata <= ~d;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		xfer(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic e);
		xfer(1'b0, a, 32'h0, r, e);
	endtask : rd
	// wait for no self-programming and no eeprom write in progress
	task automatic idle();
		logic [31:0] s;
		logic e;
		int n;
		n = 0;
		do begin
			rd(FBP_A_STATUS, s, e);
			n++;
		end while (s[5:4] !== 2'b00 && n < 100);
		if (n >= 100) begin
			hang();
		end
	endtask : idle
	// core takes no interrupts, so the store sequence is never split
	task automatic cmd(input logic [31:0] c);
		idle();
		wr(FBP_A_CTRL, c);
	endtask : cmd
endmodule : fbp_core_model

// File: verif/tb.sv
// self-checking testbench for flash boot protection
`timescale 1ns/1ps
module tb;
	import fbp_pkg::*;
	logic i_core_clk, i_resetn, psel, penable, pwrite, pready, pslverr, bhi, blo, eew, e;
	logic read_while_write_area, irq, xprog, xver, fuse, blk;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, md, sz;
	logic [4:0] flags;
	logic [31:0] zt [3] = '{32'hf800, 32'h37fe, 32'h3f00};
	logic [31:0] ct [3] = '{32'h0fc0, 32'h07bc, 32'h1ff8};
	int err_total, checks;
	assign flags = {irq, xprog, xver, fuse, blk};
	fbp_flash_protect dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_boot_size_select_hi(bhi), .i_boot_size_select_lo(blo),
		.i_eeprom_write_strobe(eew), .o_rww_busy_flag(read_while_write_area), .o_irq_allow(irq),
		.o_ext_prog_block(xprog), .o_ext_verify_block(xver), .o_fuse_lock(fuse),
		.o_boot_lock_locked(blk));
	fbp_core_model core (.i_core_clk(i_core_clk), .i_prdata(prdata), .i_pready(pready),
		.i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
		.o_paddr(paddr), .o_pwdata(pwdata));
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			$display("Error at %0t: seen %h expected %h", $time, s, x);
			err_total++;
		end
	endtask : chk
	task automatic end_sim();
		if (err_total == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		core.rd(a, r, e);
		chk(r & m, x);
	endtask : rdc
	task automatic op(input logic [31:0] c);
		core.cmd(md | c);
		core.idle();
	endtask : op
	task automatic lk(input logic [31:0] v);
		core.wr(FBP_A_DATA, v);
		op(32'h9);
	endtask : lk
	initial begin
		i_resetn = 1'b0;
		bhi = 1'b0;
		blo = 1'b0;
		eew = 1'b0;
		md = 32'h0;
		err_total = 0;
		checks = 0;
		repeat (2) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		rdc(FBP_A_LOCK, 32'hffffffff, 32'hff);
		chk(flags, 5'h10);
		core.rd(8'h40, r, e);
		chk(e, 1'b1);
		for (int c = 0; c < 4; c++) begin
			{bhi, blo} <= c[1:0];
			repeat (4) @(posedge i_core_clk);
			sz = 32'd128 << (3 - c);
			rdc(FBP_A_STATUS, 32'hffff86, ((32'h2000 - sz) << 11) | sz | (c << 1));
		end
		foreach (zt[i]) begin
			core.wr(FBP_A_ZPTR, zt[i]);
			rdc(FBP_A_CHECK, 32'h1ffc, ct[i]);
		end
		core.wr(FBP_A_ZPTR, 32'h000a);
		core.wr(FBP_A_DATA, 32'hbeef);
		op(32'h1);
		core.wr(FBP_A_ZPTR, 32'h000b);
		rdc(FBP_A_DATA, 32'hffffffff, 32'hbe);
		core.wr(FBP_A_ZPTR, 32'h000a);
		rdc(FBP_A_DATA, 32'hffffffff, 32'hef);
		core.wr(FBP_A_ZPTR, 32'h0080);
		core.cmd(32'h5);
		rdc(FBP_A_STATUS, 32'h58, 32'h18);
		core.idle();
		rdc(FBP_A_STATUS, 32'h58, 32'h08);
		op(32'h11);
		chk(read_while_write_area, 1'b0);
		op(32'h3);
		chk(read_while_write_area, 1'b1);
		op(32'h11);
		chk(read_while_write_area, 1'b0);
		lk(32'h3b);
		rdc(FBP_A_LOCK, 32'hff, 32'hfb);
		op(32'h5);
		rdc(FBP_A_STATUS, 32'h48, 32'h40);
		lk(32'h3f);
		rdc(FBP_A_LOCK, 32'hff, 32'hfb);
		op(32'h81);
		rdc(FBP_A_LOCK, 32'hff, 32'hff);
		lk(32'h2f);
		core.wr(FBP_A_ZPTR, 32'h3f00);
		op(32'h5);
		rdc(FBP_A_STATUS, 32'h48, 32'h40);
		op(32'h81);
		op(32'h3);
		rdc(FBP_A_STATUS, 32'h48, 32'h00);
		lk(32'h3e);
		chk(flags, 5'h1a);
		lk(32'h3c);
		chk(flags, 5'h1f);
		op(32'h81);
		lk(32'h37);
		md = 32'h100;
		core.wr(FBP_A_CTRL, md);
		core.wr(FBP_A_ZPTR, 32'h000a);
		chk(irq, 1'b0);
		md = 32'h300;
		core.wr(FBP_A_CTRL, md);
		rdc(FBP_A_DATA, 32'hffffffff, 32'h0);
		rdc(FBP_A_CHECK, 32'h400, 32'h0);
		chk(irq, 1'b1);
		md = 32'h0;
		op(32'h81);
		lk(32'h1f);
		md = 32'h200;
		core.wr(FBP_A_CTRL, md);
		core.wr(FBP_A_ZPTR, 32'h3f00);
		chk(irq, 1'b0);
		md = 32'h0;
		core.wr(FBP_A_CTRL, md);
		rdc(FBP_A_CHECK, 32'h400, 32'h0);
		rdc(FBP_A_DATA, 32'hffffffff, 32'h0);
		op(32'h81);
		eew <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		core.wr(FBP_A_CTRL, 32'h5);
		rdc(FBP_A_STATUS, 32'h30, 32'h20);
		eew <= 1'b0;
		end_sim();
	end
endmodule : tb
